// file: sfp_port.v
// sfp_port.v: clock-synchronous serial programming port with command decoder
// assumes ref_clk far faster than the transfer clock; flash core sits outside
//
// Operation
// - enter mode when three pins high at release
// - eight-bit units, least significant bit first
// - sample receive line on rising clock edge
// - change transmit line on falling clock edge
// - handshake low when ready, high on reception
// - handshake high through every busy period
// - only user area programmable, boot refused
// - seven-byte identification code is the key
// - non-blank flash rejects commands other than read-status and id check until id matches
// - return memory or status after command
// - read-status returns two status bytes
// - clear-status clears error bits, then ready
// - page program: command, two addresses, 256 bytes
// - blank flash accepts every command
`include "sfp_consts.vh"

module sfp_port (
   ref_clk,
   resetn,
   transfer_clock_pin,
   receive_data_pin,
   mode_select_irq_pin,
   operating_mode_pin,
   transmit_data_pin,
   handshake_ready_pin,
   serial_mode,
   flash_blank,
   flash_busy,
   flash_prog_fail,
   flash_erase_fail,
   flash_rd_data,
   stored_id_flat,
   flash_addr,
   flash_wr_data,
   flash_wr_stb,
   flash_erase_stb
);
   input  wire        ref_clk;             // 10 mhz block clock
   input  wire        resetn;              // synchronous reset, active low
   input  wire        transfer_clock_pin;  // clock from programmer
   input  wire        receive_data_pin;    // serial data in
   input  wire        mode_select_irq_pin; // mode strap
   input  wire        operating_mode_pin;  // mode strap
   output reg         transmit_data_pin;   // serial data out
   output wire        handshake_ready_pin; // high while busy
   output reg         serial_mode;         // programming mode latched
   input  wire        flash_blank;         // whole flash erased
   input  wire        flash_busy;          // core program or erase running
   input  wire        flash_prog_fail;     // pulse: program error
   input  wire        flash_erase_fail;    // pulse: erase error
   input  wire [7:0]  flash_rd_data;       // byte at flash_addr
   input  wire [55:0] stored_id_flat;      // stored key, byte 0 low
   output reg  [15:0] flash_addr;          // byte address to core
   output reg  [7:0]  flash_wr_data;       // write byte
   output reg         flash_wr_stb;        // one-cycle write pulse
   output reg         flash_erase_stb;     // one-cycle erase-all pulse

   // ****************************************************************
   // pin synchronisers
   // ****************************************************************
   reg [1:0] sck_sync_reg;  // stage 0 read only by stage 1
   reg [1:0] rxd_sync_reg;
   reg [1:0] irq_sync_reg;
   reg [1:0] cnv_sync_reg;
   reg       sck_prev_reg;  // last synchronised clock level
   wire      sck_rise = sck_sync_reg[1] & ~sck_prev_reg;
   wire      sck_fall = ~sck_sync_reg[1] & sck_prev_reg;

   // two flops on every pin before any logic looks at it
   always @(posedge ref_clk) begin
      if (!resetn) begin
         // clock stages rest high like the idle pin, so release shows no false edge
         sck_sync_reg <= 2'h3;
         rxd_sync_reg <= 2'h0;
         irq_sync_reg <= 2'h0;
         cnv_sync_reg <= 2'h0;
         sck_prev_reg <= 1'h1;
      end else begin
         sck_sync_reg <= {sck_sync_reg[0], transfer_clock_pin};
         rxd_sync_reg <= {rxd_sync_reg[0], receive_data_pin};
         irq_sync_reg <= {irq_sync_reg[0], mode_select_irq_pin};
         cnv_sync_reg <= {cnv_sync_reg[0], operating_mode_pin};
         sck_prev_reg <= sck_sync_reg[1];
      end
   end

   // ****************************************************************
   // mode strap capture
   // ****************************************************************
   reg strap_done_reg; // strap sampled once after release
   reg [1:0] strap_wait_reg; // lets synchronisers fill first

   // straps sampled in clocked logic after release, never under reset
   always @(posedge ref_clk) begin
      if (!resetn) begin
         strap_done_reg <= 1'h0;
         strap_wait_reg <= 2'h0;
         serial_mode    <= 1'h0;
      end else if (!strap_done_reg) begin
         strap_wait_reg <= strap_wait_reg + 2'h1;
         if (strap_wait_reg == 2'h2) begin
            strap_done_reg <= 1'h1;
            serial_mode    <= sck_sync_reg[1] & irq_sync_reg[1]
                              & cnv_sync_reg[1];
         end
      end
   end

   // ****************************************************************
   // shifter and command decoder
   // ****************************************************************
   localparam ST_IDLE = 2'h0; // waiting for a byte
   localparam ST_EXEC = 2'h1; // waiting on flash core
   localparam ST_TX   = 2'h2; // transmit byte in progress

   reg [1:0]  state_reg;
   reg [7:0]  rx_shift_reg;   // lsb arrives first
   reg [3:0]  bit_cnt_reg;    // bits of the current unit
   reg [7:0]  tx_shift_reg;
   reg [8:0]  byte_idx_reg;   // byte number within command
   reg [7:0]  cmd_reg;        // first byte of command
   reg [7:0]  status_reg;     // status byte
   reg        id_ok_reg;      // key accepted
   reg        id_bad_reg;     // mismatch seen in this check
   reg        in_rx_reg;      // receive unit started
   reg        exec_reg;       // command completes after core idle
   wire       error_bits = status_reg[`SFP_SR_ERASE_BIT] | status_reg[`SFP_SR_PROG_BIT];
   wire       unlocked   = id_ok_reg | flash_blank;
   wire [2:0] id_pos     = byte_idx_reg[2:0] - 3'h5; // key byte index
   wire [7:0] rx_byte    = {rxd_sync_reg[1], rx_shift_reg[7:1]}; // only the second stage

   // high whenever a unit is moving or the core works
   assign handshake_ready_pin = ~serial_mode | in_rx_reg | (state_reg != ST_IDLE)
                                | flash_busy;

   // the receive byte and the full command flow
   always @(posedge ref_clk) begin
      if (!resetn) begin
         state_reg <= ST_IDLE;
         rx_shift_reg <= 8'h00;
         bit_cnt_reg <= 4'h0;
         tx_shift_reg <= 8'h00;
         byte_idx_reg <= 9'h000;
         cmd_reg <= 8'h00;
         status_reg <= `SFP_SR_RESET;
         id_ok_reg <= 1'h0;
         id_bad_reg <= 1'h0;
         in_rx_reg <= 1'h0;
         exec_reg <= 1'h0;
         transmit_data_pin <= 1'h1;
         flash_addr <= 16'h0000;
         flash_wr_data <= 8'h00;
         flash_wr_stb <= 1'h0;
         flash_erase_stb <= 1'h0;
      end else begin
         flash_wr_stb <= 1'h0;
         flash_erase_stb <= 1'h0;
         status_reg[`SFP_SR_READY_BIT] <= ~flash_busy;
         // error pulses set bits; set beats a clear in the same cycle
         if (flash_prog_fail)
            status_reg[`SFP_SR_PROG_BIT] <= 1'h1;
         if (flash_erase_fail)
            status_reg[`SFP_SR_ERASE_BIT] <= 1'h1;
         case (state_reg)
            ST_IDLE: begin
               if (serial_mode && sck_rise) begin
                  in_rx_reg <= 1'h1;
                  rx_shift_reg <= rx_byte;
                  bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  if (bit_cnt_reg == `SFP_BYTE_BITS - 4'h1) begin
                     bit_cnt_reg <= 4'h0;
                     in_rx_reg <= 1'h0;
                     byte_idx_reg <= byte_idx_reg + 9'h001;
                     if (byte_idx_reg == 9'h000) begin
                        cmd_reg <= rx_byte;
                        if (rx_byte == `SFP_CMD_READ_STATUS) begin
                           tx_shift_reg <= status_reg;
                           state_reg <= ST_TX;
                        end else if (rx_byte == `SFP_CMD_CLEAR_STATUS) begin
                           byte_idx_reg <= 9'h000;
                           if (unlocked) begin
                              if (!flash_prog_fail)
                                 status_reg[`SFP_SR_PROG_BIT] <= 1'h0;
                              if (!flash_erase_fail)
                                 status_reg[`SFP_SR_ERASE_BIT] <= 1'h0;
                           end
                        end else if (rx_byte == `SFP_CMD_ID_CHECK) begin
                           id_bad_reg <= 1'h0;
                        end else if (!unlocked) begin
                           byte_idx_reg <= 9'h000; // gated command dropped
                        end
                     end else begin
                        case (cmd_reg)
                           `SFP_CMD_PAGE_READ, `SFP_CMD_PAGE_PROG: begin
                              if (byte_idx_reg == 9'h001)
                                 flash_addr[15:8] <= rx_byte;
                              else if (byte_idx_reg == 9'h002)
                                 flash_addr[7:0] <= 8'h00; // high byte must be zero
                              else begin
                                 flash_wr_data <= rx_byte;
                                 flash_wr_stb <= flash_addr[15:8] < `SFP_BOOT_PAGE_FIRST;
                                 if (flash_addr[15:8] >= `SFP_BOOT_PAGE_FIRST)
                                    status_reg[`SFP_SR_PROG_BIT] <= 1'h1;
                                 exec_reg <= 1'h1;
                                 state_reg <= ST_EXEC;
                              end
                              if (cmd_reg == `SFP_CMD_PAGE_READ && byte_idx_reg == 9'h002) begin
                                 // data fetched at the first falling edge, once the address settles
                                 state_reg <= ST_TX;
                              end
                           end
                           `SFP_CMD_ERASE_ALL: begin
                              byte_idx_reg <= 9'h000;
                              if (rx_byte == `SFP_CMD_ERASE_OK) begin
                                 flash_erase_stb <= 1'h1; // user area only
                                 exec_reg <= 1'h1;
                                 state_reg <= ST_EXEC;
                              end else begin
                                 status_reg[`SFP_SR_PROG_BIT] <= 1'h1;
                                 status_reg[`SFP_SR_ERASE_BIT] <= 1'h1;
                              end
                           end
                           `SFP_CMD_ID_CHECK: begin
                              if (byte_idx_reg >= `SFP_ID_HDR_BYTES) begin
                                 if (rx_byte != stored_id_flat[id_pos*8 +: 8])
                                    id_bad_reg <= 1'h1;
                                 if (id_pos == `SFP_ID_BYTES - 3'h1) begin
                                    byte_idx_reg <= 9'h000;
                                    id_ok_reg <= ~id_bad_reg &
                                       (rx_byte == stored_id_flat[id_pos*8 +: 8]);
                                 end
                              end
                           end
                           default: byte_idx_reg <= 9'h000;
                        endcase
                     end
                  end
               end
            end
            ST_EXEC: begin
               // wait for the core to finish before ready again
               if (!flash_busy && !flash_wr_stb && !flash_erase_stb) begin
                  exec_reg <= 1'h0;
                  state_reg <= ST_IDLE;
                  if (cmd_reg == `SFP_CMD_PAGE_PROG) begin
                     flash_addr[7:0] <= flash_addr[7:0] + 8'h01;
                     if (byte_idx_reg == `SFP_PAGE_BYTES + 9'h003)
                        byte_idx_reg <= 9'h000; // page done
                  end
               end
            end
            ST_TX: begin
               // launch bits on falling edges, lsb first
               if (sck_fall) begin
                  bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  if (cmd_reg == `SFP_CMD_PAGE_READ && bit_cnt_reg == 4'h0) begin
                     // page byte taken straight from the core at the current address
                     transmit_data_pin <= flash_rd_data[0];
                     tx_shift_reg <= {1'b0, flash_rd_data[7:1]};
                  end else begin
                     transmit_data_pin <= tx_shift_reg[0];
                     tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
                  end
               end
               if (sck_rise && bit_cnt_reg == `SFP_BYTE_BITS) begin
                  bit_cnt_reg <= 4'h0;
                  byte_idx_reg <= byte_idx_reg + 9'h001;
                  state_reg <= ST_TX;
                  if (cmd_reg == `SFP_CMD_READ_STATUS) begin
                     if (byte_idx_reg == 9'h001)
                        tx_shift_reg <= {6'h00, error_bits, status_reg[`SFP_SR_READY_BIT]};
                     else begin
                        byte_idx_reg <= 9'h000;
                        state_reg <= ST_IDLE;
                     end
                  end else begin
                     flash_addr[7:0] <= flash_addr[7:0] + 8'h01; // next page byte
                     if (byte_idx_reg == `SFP_PAGE_BYTES + 9'h002) begin
                        byte_idx_reg <= 9'h000;
                        state_reg <= ST_IDLE;
                     end
                  end
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

endmodule

// file: sfp_consts.vh
// sfp_consts.vh: constants for the serial flash programming port
// assumes inclusion by bare name from the port's design file
`ifndef SFP_CONSTS_VH
`define SFP_CONSTS_VH

// ****************************************************************
// command codes
// ****************************************************************
`define SFP_CMD_PAGE_READ    8'hff
`define SFP_CMD_PAGE_PROG    8'h41
`define SFP_CMD_ERASE_ALL    8'ha7
`define SFP_CMD_ERASE_OK     8'hd0
`define SFP_CMD_READ_STATUS  8'h70
`define SFP_CMD_CLEAR_STATUS 8'h50
`define SFP_CMD_ID_CHECK     8'hf5

// ****************************************************************
// sizes and status fields
// ****************************************************************
`define SFP_BYTE_BITS        4'h8
`define SFP_PAGE_BYTES       9'h100
`define SFP_ID_BYTES         3'h7
`define SFP_ID_HDR_BYTES     9'h005
`define SFP_BOOT_PAGE_FIRST  8'hf0
`define SFP_SR_READY_BIT     7
`define SFP_SR_ERASE_BIT     5
`define SFP_SR_PROG_BIT      4
`define SFP_SR_RESET         8'h80

`endif

// file: sfp_port_props.sv
// sfp_port_props.sv: pin-level assertions for the serial programming port
// assumes one ref_clk domain and the bind at the foot of this file
// ****************************************************************
// checker
// ****************************************************************
module sfp_port_props (
   input wire        ref_clk,
   input wire        resetn,
   input wire        transfer_clock_pin,
   input wire        transmit_data_pin,
   input wire        handshake_ready_pin,
   input wire        serial_mode,
   input wire        flash_busy,
   input wire [15:0] flash_addr,
   input wire        flash_wr_stb,
   input wire        flash_erase_stb
);
   timeunit 1ns;
   timeprecision 1ns;
   reg [3:0] rel_cnt_reg; // cycles since reset release, saturating
   // count from release so mode entry can be bounded
   always @(posedge ref_clk) begin
      if (!resetn)
         rel_cnt_reg <= 4'h0;
      else if (rel_cnt_reg != 4'hf)
         rel_cnt_reg <= rel_cnt_reg + 4'h1;
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   sequence clk_rise_s;
      serial_mode && $rose(transfer_clock_pin);
   endsequence
   sequence busy_soon_s;
      ##[0:6] handshake_ready_pin;
   endsequence
   reset_out_a: assert property (disable iff (1'b0) !resetn |=> handshake_ready_pin
      && transmit_data_pin && !flash_wr_stb && !flash_erase_stb)
      else $error("outputs not at rest after reset");
   rx_busy_a: assert property (clk_rise_s |-> busy_soon_s)
      else $error("handshake not busy after a received bit");
   core_busy_a: assert property (serial_mode && flash_busy |-> handshake_ready_pin)
      else $error("ready shown while core busy");
   boot_guard_a: assert property (flash_wr_stb |-> flash_addr[15:8] < 8'hf0)
      else $error("write reached the boot area");
   wr_pulse_a: assert property (flash_wr_stb |=> !flash_wr_stb)
      else $error("write strobe longer than one cycle");
   erase_pulse_a: assert property (flash_erase_stb |=> !flash_erase_stb [*2])
      else $error("erase strobe repeated");
   mode_entry_a: assert property ($rose(serial_mode) |-> rel_cnt_reg < 4'h8)
      else $error("mode entered long after release");
   mode_hold_a: assert property (serial_mode |=> serial_mode)
      else $error("mode left without reset");
   idle_busy_a: assert property (!serial_mode |-> handshake_ready_pin && !flash_wr_stb)
      else $error("port active outside programming mode");
   // output bits move only in the low half of the transfer clock
   tx_edge_a: assert property ($changed(transmit_data_pin) |-> !transfer_clock_pin)
      else $error("transmit line changed while transfer clock high");
endmodule
bind sfp_port sfp_port_props chk_i (.ref_clk(ref_clk), .resetn(resetn),
   .transfer_clock_pin(transfer_clock_pin), .transmit_data_pin(transmit_data_pin),
   .handshake_ready_pin(handshake_ready_pin), .serial_mode(serial_mode),
   .flash_busy(flash_busy), .flash_addr(flash_addr), .flash_wr_stb(flash_wr_stb),
   .flash_erase_stb(flash_erase_stb));

// file: sfp_prog_model.sv
// sfp_prog_model.sv: behavioural serial programmer at the port's far side
// assumes ref_clk from the bench; pins move only at its falling edges
module sfp_prog_model (
   input  wire  ref_clk,
   output logic transfer_clock_pin,
   output logic receive_data_pin,
   input  wire  transmit_data_pin,
   input  wire  handshake_ready_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   int late = 0; // ready waits that ran out
   // clock idles high, as mode entry needs it high at release
   initial begin
      transfer_clock_pin = 1'b1;
      receive_data_pin = 1'b1;
   end
   // one byte, lsb first, 800 ns clock; wait_rdy holds off until ready
   task automatic xfer(input logic [7:0] tx, input bit wait_rdy, output logic [7:0] rx);
      int n;
      n = 0;
      repeat (8) @(negedge ref_clk);
      while (wait_rdy && handshake_ready_pin !== 1'b0 && n < 400) begin
         @(negedge ref_clk);
         n++;
      end
      if (n == 400)
         late++;
      for (int i = 0; i < 8; i++) begin
         transfer_clock_pin = 1'b0;
         receive_data_pin = tx[i];
         repeat (4) @(negedge ref_clk);
         rx[i] = transmit_data_pin;
         transfer_clock_pin = 1'b1;
         repeat (4) @(negedge ref_clk);
      end
      receive_data_pin = ~tx[7]; // released: no held value to lean on
   endtask
endmodule

// file: tb.sv
// tb.sv: self-checking bench for the serial programming port
// assumes the port, its checker and the programmer model compiled first
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk, resetn, sclk, rxd, irq_pin, mode_pin, txd, hs, smode;
   logic flash_blank, flash_busy, prog_fail, erase_fail, wr_stb, er_stb;
   logic [15:0] addr;
   logic [7:0]  wr_data, rd, r;
   logic [55:0] key = 56'h0d1c2b3a495867; // stored key, byte 0 lowest
   int num_errors = 0, num_checks = 0, cyc = 0, wr_cnt = 0, er_cnt = 0, busy_cnt = 0;
   bit fail_en = 0; // make the next erase end in error
   sfp_port dut (.ref_clk(ref_clk), .resetn(resetn), .transfer_clock_pin(sclk),
      .receive_data_pin(rxd), .mode_select_irq_pin(irq_pin), .operating_mode_pin(mode_pin),
      .transmit_data_pin(txd), .handshake_ready_pin(hs), .serial_mode(smode),
      .flash_blank(flash_blank), .flash_busy(flash_busy), .flash_prog_fail(prog_fail),
      .flash_erase_fail(erase_fail), .flash_rd_data(rd), .stored_id_flat(key),
      .flash_addr(addr), .flash_wr_data(wr_data), .flash_wr_stb(wr_stb),
      .flash_erase_stb(er_stb));
   sfp_prog_model prog (.ref_clk(ref_clk), .transfer_clock_pin(sclk),
      .receive_data_pin(rxd), .transmit_data_pin(txd), .handshake_ready_pin(hs));
   assign rd = addr[15:8] ^ addr[7:0] ^ 8'h5a; // core read model, page mixed in
   // block clock runs free from time zero, through the whole reset
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   // monitors mid-cycle, where registered outputs have settled
   always @(negedge ref_clk) begin
      cyc++;
      if (cyc == 80000) begin
         num_errors++;
         tally_and_finish;
      end else if (wr_stb === 1'b1) begin
         chk(addr, {8'h12, wr_cnt[7:0]});
         chk(wr_data, wr_cnt[7:0] ^ 8'h3c);
         wr_cnt++;
      end else if (er_stb === 1'b1)
         er_cnt++;
   end
   // core model: erase keeps the core busy a while, may end in error
   always @(negedge ref_clk) begin
      erase_fail <= 1'b0;
      if (er_stb === 1'b1)
         busy_cnt = 30;
      else if (busy_cnt > 0)
         busy_cnt--;
      flash_busy <= (busy_cnt > 1);
      if (busy_cnt == 1 && fail_en)
         erase_fail <= 1'b1;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic send(input logic [7:0] b);
      prog.xfer(b, 1'b1, r);
   endtask
   task automatic status(input logic [7:0] e1, input logic [7:0] e2);
      send(8'h70);
      prog.xfer(8'h00, 1'b0, r);
      chk(r, e1);
      prog.xfer(8'h00, 1'b0, r);
      chk(r, e2);
   endtask
   // page program: command, middle and high address, then 256 bytes
   task automatic page(input logic [7:0] pg, input bit ramp);
      send(8'h41);
      send(pg);
      send(8'h00);
      for (int i = 0; i < 256; i++)
         send(ramp ? i[7:0] ^ 8'h3c : 8'h00);
   endtask
   task automatic t_mode;
      repeat (8) @(negedge ref_clk);
      chk(smode, 1'b1);
      chk(hs, 1'b0);
      $display("mode entry test done");
   endtask
   task automatic t_locked;
      send(8'ha7);
      send(8'hd0);
      status(8'h80, 8'h01);
      chk(er_cnt[15:0], 16'h0000);
      flash_blank = 1'b1;
      send(8'ha7);
      send(8'hd0);
      chk(er_cnt[15:0], 16'h0001);
      flash_blank = 1'b0;
      $display("locked test done");
   endtask
   // page read: command, middle and high address, then 256 bytes out
   task automatic t_read;
      send(8'hff);
      send(8'h12);
      send(8'h00);
      for (int i = 0; i < 256; i++) begin
         prog.xfer(8'h00, 1'b0, r);
         chk(r, i[7:0] ^ 8'h48);
      end
      status(8'h80, 8'h01);
      $display("page read test done");
   endtask
   task automatic t_program;
      send(8'hf5);
      send(8'hd4);
      send(8'hff);
      send(8'h00);
      send(8'h07);
      for (int i = 0; i < 7; i++)
         send(key[8*i +: 8]);
      page(8'h12, 1'b1);
      status(8'h80, 8'h01);
      chk(wr_cnt[15:0], 16'h0100);
      $display("id and program test done");
   endtask
   task automatic t_boot;
      page(8'hf0, 1'b0);
      status(8'h90, 8'h03);
      chk(wr_cnt[15:0], 16'h0100);
      send(8'h50);
      status(8'h80, 8'h01);
      $display("boot refusal test done");
   endtask
   task automatic t_erase;
      fail_en = 1'b1;
      send(8'ha7);
      send(8'hd0);
      status(8'ha0, 8'h03);
      chk(er_cnt[15:0], 16'h0002);
      send(8'h50);
      status(8'h80, 8'h01);
      $display("erase test done");
   endtask
   task tally_and_finish;
      $display("checks %0d, mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      resetn = 1'b0;
      irq_pin = 1'b1;
      mode_pin = 1'b1;
      flash_blank = 1'b0;
      prog_fail = 1'b0;
      repeat (3) @(negedge ref_clk);
      resetn = 1'b1;
      t_mode;
      t_locked;
      t_program;
      t_read;
      t_boot;
      t_erase;
      chk(prog.late[15:0], 16'h0000);
      tally_and_finish;
   end
endmodule
